//--- rtl/swt_defines.vh
/*
 sleep/wake timing constants: reset values, ranges, status bit positions, tick counts.
 assumes a 100 MHz clock.
*/
`ifndef SWT_DEFINES_VH
`define SWT_DEFINES_VH
`define SWT_CLK_MHZ 100
`define SWT_MS_NS 1000000
`define SWT_CLK_NS 10
`define SWT_MS_CYCLES (`SWT_MS_NS / `SWT_CLK_NS)
`define SWT_TEN_MS 10
`define SWT_WAKE_MIN 24'h000001
`define SWT_WAKE_MAX 24'h36ee80
`define SWT_WAKE_RST 24'h001f40
`define SWT_SLEEP_MAX 24'h15f900
`define SWT_SLEEP_RST 24'h000190
`define SWT_WHD_RST 16'h0000
`define SWT_CNT_MAX 16'hffff
`define SWT_STATUS_RST 8'h40
`define SWT_MODE_ASYNC 4'h4
`define SWT_MODE_ASYNC_PIN 4'h5
`define SWT_MODE_SUPPORT 4'h7
`define SWT_MODE_SYNC 4'h8
`define SWT_ST_NET_WAKE 0
`define SWT_ST_COORD 1
`define SWT_ST_EVER_SYNC 2
`define SWT_ST_CYC_SYNC 3
`define SWT_ST_SETTINGS_NOM 4
`define SWT_ST_REQ_NOM 5
`define SWT_ST_DEPLOY 6
`endif

//--- rtl/swt_sleep_wake_timing.v
/*
 sleep/wake timing controller with status flags, operating readouts and sync counters.
 assumes host writes arrive as one-cycle strobes with data, synchronous to clock;
 network events (sync received, coordinator, deployment) come from the radio logic.
*/
// What this block does
// - async sleep stays awake wake time after data
// - sync sleep wake interval at least wake time
// - too-small wake time raised to minimum
// - wake time ms units, clamped, reset 8 s
// - wake-host delay gates output after waking
// - host character stops wake-host delay
// - sync sleep shortened by wake-host delay
// - sync wake at least delay plus unicast
// - status bits network wake, coordinator
// - status bits ever synced, synced this cycle
// - status bits settings and requested nomination
// - status deployment bit, reset 0x40
// - operating sleep readout, sync or configured
// - operating wake readout, sync or configured
// - cycles since sync counter, starts zero
// - missed sleep sync counter increments
// - host writes zero to clear counter
// - missed sync counter saturates at max
// - mode 4 selects async cyclic sleep
// - sleep period 10 ms units, zero none
`timescale 1ns/1ps
`include "swt_defines.vh"

module swt_sleep_wake_timing #(
  parameter MS_CYCLES = `SWT_MS_CYCLES, // clock cycles per millisecond
  parameter UNICAST_MS = 16'h0020 // time to send one single-hop unicast
) (
  input wire clock, // 100 MHz clock
  input wire rst_b, // synchronous reset, active low
  input wire [3:0] sleep_mode_select, // sleep mode setting
  input wire wake_time_wr, // strobe: write wake time
  input wire [23:0] wake_time_wdata, // wake time in ms
  input wire [23:0] wake_time_min, // minimum from other sleep settings
  input wire sleep_period_wr, // strobe: write sleep period
  input wire [23:0] sleep_period_wdata, // sleep period in 10 ms
  input wire wake_host_delay_wr, // strobe: write wake-host delay
  input wire [15:0] wake_host_delay_wdata, // wake-host delay in ms
  input wire missed_sync_clr_wr, // strobe: write missed sync count
  input wire [15:0] missed_sync_wdata, // written value, zero clears
  input wire rx_data, // pulse: radio or serial data received
  input wire host_char, // pulse: serial character from host
  input wire sync_rx, // pulse: valid sync message received
  input wire [23:0] sync_sleep, // network sleep time from sync
  input wire [23:0] sync_wake, // network wake time from sync
  input wire is_coordinator, // node acts as sleep coordinator
  input wire settings_nominate, // changed settings force self nomination
  input wire request_nominate, // nomination asked by button or command
  input wire deploy_mode, // node in deployment mode
  output reg awake_q, // device awake
  output reg host_out_ok_q, // serial output and samples allowed
  output reg [23:0] wake_time_q, // stored wake time
  output reg [23:0] sleep_period_q, // stored sleep period
  output reg [15:0] wake_host_delay_q, // stored wake-host delay
  output reg [7:0] network_sleep_state_flags_q, // status word
  output reg [23:0] operating_sleep_readout_q, // operating sleep time
  output reg [23:0] operating_wake_readout_q, // operating wake time
  output reg [15:0] cycles_since_sync_q, // cycles since last sync
  output reg [15:0] missed_sync_cycle_count_q // sleep cycles without sync
);

  // sequencer states, one-hot
  // idle means no cyclic sleep: always awake, timers parked
  localparam ST_AWAKE = 3'b001;
  localparam ST_SLEEP = 3'b010;
  localparam ST_IDLE = 3'b100;

  reg [2:0] state_q, state_d;
  reg [31:0] pre_q;
  reg [3:0] ten_q;
  reg ms_tick_q;
  reg ten_tick_q;
  reg [23:0] timer_q, timer_d;
  reg [15:0] whd_cnt_q;
  reg synced_q;
  reg ever_sync_q;
  reg cyc_sync_q;
  wire async_mode;
  wire sync_mode;
  wire [23:0] eff_wake;
  wire [23:0] eff_sleep;
  wire [23:0] sync_wake_floor;
  wire [23:0] sync_wake_len;
  wire [23:0] sync_sleep_ms;
  wire [23:0] sleep_len;
  wire wake_end;
  wire sleep_end;
  wire [23:0] wt_lo;
  wire [23:0] wt_clamped;
  // restarts the tick dividers at the start of every timed interval
  wire tick_restart;
  // tick that the running interval counts
  wire cur_tick;

  assign async_mode = (sleep_mode_select == `SWT_MODE_ASYNC) ||
                      (sleep_mode_select == `SWT_MODE_ASYNC_PIN);
  assign sync_mode = (sleep_mode_select == `SWT_MODE_SYNC) ||
                     (sleep_mode_select == `SWT_MODE_SUPPORT);

  // wake time clamp to minimum and range
  assign wt_lo = (wake_time_min > `SWT_WAKE_MIN) ? wake_time_min : `SWT_WAKE_MIN;
  assign wt_clamped = (wake_time_wdata < wt_lo) ? wt_lo :
                      (wake_time_wdata > `SWT_WAKE_MAX) ? `SWT_WAKE_MAX : wake_time_wdata;

  // timing used once synchronised, else configured values
  assign eff_wake = synced_q ? sync_wake : wake_time_q;
  assign eff_sleep = synced_q ? sync_sleep : sleep_period_q;

  // in sync sleep the awake window must leave room for the host delay
  // and one unicast, whatever the network schedule asks for
  // sync wake floor of delay plus unicast
  assign sync_wake_floor = {8'h00, wake_host_delay_q} + {8'h00, UNICAST_MS};
  assign sync_wake_len = (eff_wake > sync_wake_floor) ? eff_wake : sync_wake_floor;

  // sync sleep shortened by wake-host delay, in ms
  assign sync_sleep_ms = (eff_sleep[19:0] * 4'd10) > {8'h00, wake_host_delay_q} ?
                         ((eff_sleep[19:0] * 4'd10) - {8'h00, wake_host_delay_q}) : 24'h000001;
  // sleep period in 10 ms ticks, ms ticks in sync mode
  assign sleep_len = sync_mode ? sync_sleep_ms : eff_sleep;

  // restart the dividers whenever an interval starts, so that each
  // interval lasts its full count of ticks instead of drifting with
  // the phase of free-running dividers; a data restart counts too
  assign tick_restart = (state_d != state_q) ||
                        (state_q == ST_AWAKE && async_mode && rx_data);
  // async sleep counts 10 ms ticks, every other interval ms ticks
  assign cur_tick = (state_q == ST_SLEEP && !sync_mode) ? ten_tick_q : ms_tick_q;
  // an interval ends on the tick that takes its timer from one to zero,
  // or at once when it was loaded with zero
  assign wake_end = (timer_q == 24'h000000) || (timer_q == 24'h000001 && cur_tick);
  assign sleep_end = (timer_q == 24'h000000) || (timer_q == 24'h000001 && cur_tick);

  // millisecond and 10 ms tick generators
  // both dividers start over with each interval, see tick_restart
  always @(posedge clock) begin
    if (!rst_b || tick_restart) begin
      pre_q <= 32'h00000000;
      ten_q <= 4'h0;
      ms_tick_q <= 1'b0;
      ten_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= 1'b0;
      ten_tick_q <= 1'b0;
      if (pre_q == MS_CYCLES - 1) begin
        pre_q <= 32'h00000000;
        ms_tick_q <= 1'b1;
        if (ten_q == `SWT_TEN_MS - 1) begin
          ten_q <= 4'h0;
          ten_tick_q <= 1'b1;
        end else begin
          ten_q <= ten_q + 4'h1;
        end
      end else begin
        pre_q <= pre_q + 32'h00000001;
      end
    end
  end

  // host-written settings
  // writes take effect at the strobe edge; the wake floor is applied
  // again whenever the other sleep settings raise it
  always @(posedge clock) begin
    if (!rst_b) begin
      wake_time_q <= `SWT_WAKE_RST;
      sleep_period_q <= `SWT_SLEEP_RST;
      wake_host_delay_q <= `SWT_WHD_RST;
    end else begin
      if (wake_time_wr) begin
        wake_time_q <= wt_clamped;
      end else if (wake_time_q < wake_time_min) begin
        wake_time_q <= (wake_time_min > `SWT_WAKE_MAX) ? `SWT_WAKE_MAX : wake_time_min;
      end
      if (sleep_period_wr) begin
        sleep_period_q <= (sleep_period_wdata > `SWT_SLEEP_MAX) ? `SWT_SLEEP_MAX :
                          sleep_period_wdata;
      end
      if (wake_host_delay_wr) begin
        wake_host_delay_q <= wake_host_delay_wdata;
      end
    end
  end

  // sleep/wake sequencer next state
  // the timer is loaded on entry to each interval and counts down on
  // the interval's own tick; leaving the cyclic modes parks it in idle
  always @* begin
    state_d = state_q;
    timer_d = timer_q;
    case (state_q)
      ST_IDLE: begin
        timer_d = sync_mode ? sync_wake_len : eff_wake;
        if ((async_mode || sync_mode) && eff_sleep != 24'h000000) begin
          state_d = ST_AWAKE;
        end
      end
      ST_AWAKE: begin
        if (async_mode && rx_data) begin
          timer_d = eff_wake;
        end else if (!(async_mode || sync_mode) || eff_sleep == 24'h000000) begin
          state_d = ST_IDLE;
        end else if (wake_end) begin
          state_d = ST_SLEEP;
          timer_d = sleep_len;
        end else if (ms_tick_q) begin
          timer_d = timer_q - 24'h000001;
        end
      end
      ST_SLEEP: begin
        if (!(async_mode || sync_mode)) begin
          state_d = ST_IDLE;
        end else if (sleep_end) begin
          // sync wake interval from wake time
          state_d = ST_AWAKE;
          timer_d = sync_mode ? sync_wake_len : eff_wake;
        end else if (sync_mode ? ms_tick_q : ten_tick_q) begin
          timer_d = timer_q - 24'h000001;
        end
      end
      default: begin
        state_d = ST_IDLE;
        timer_d = 24'h000000;
      end
    endcase
  end

  // sequencer registers and awake output
  always @(posedge clock) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      timer_q <= 24'h000000;
      awake_q <= 1'b1;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      awake_q <= (state_d != ST_SLEEP);
    end
  end

  // wake-host delay after each wake
  // output is held back only while asleep or while the delay runs; going to sleep
  // blocks it, a host character releases it at once
  always @(posedge clock) begin
    if (!rst_b) begin
      whd_cnt_q <= 16'h0000;
      host_out_ok_q <= 1'b1;
    end else if (state_q == ST_SLEEP && state_d == ST_AWAKE) begin
      whd_cnt_q <= wake_host_delay_q;
      host_out_ok_q <= (wake_host_delay_q == 16'h0000);
    end else if (state_d == ST_SLEEP) begin
      host_out_ok_q <= 1'b0;
    end else if (host_char) begin
      whd_cnt_q <= 16'h0000;
      host_out_ok_q <= 1'b1;
    end else if (whd_cnt_q != 16'h0000) begin
      if (ms_tick_q) begin
        whd_cnt_q <= whd_cnt_q - 16'h0001;
        host_out_ok_q <= (whd_cnt_q == 16'h0001);
      end
    end else begin
      host_out_ok_q <= 1'b1;
    end
  end

  // sync tracking and cycle counters
  // a sync in the boundary cycle counts for the new interval;
  // a missed-cycle increment beats a host clear in the same cycle
  always @(posedge clock) begin
    if (!rst_b) begin
      synced_q <= 1'b0;
      ever_sync_q <= 1'b0;
      cyc_sync_q <= 1'b0;
      cycles_since_sync_q <= 16'h0000;
      missed_sync_cycle_count_q <= 16'h0000;
    end else begin
      if (sync_rx) begin
        synced_q <= 1'b1;
      end
      if (sync_rx) begin
        ever_sync_q <= 1'b1;
      end
      if (state_q != state_d && state_q != ST_IDLE && state_d != ST_IDLE) begin
        cyc_sync_q <= sync_rx;
        if (sync_rx) begin
          cycles_since_sync_q <= 16'h0000;
        end else if (cycles_since_sync_q != `SWT_CNT_MAX) begin
          cycles_since_sync_q <= cycles_since_sync_q + 16'h0001;
        end
      end else if (sync_rx) begin
        cyc_sync_q <= 1'b1;
        cycles_since_sync_q <= 16'h0000;
      end
      if (state_q == ST_SLEEP && state_d == ST_AWAKE && !cyc_sync_q && !sync_rx &&
          missed_sync_cycle_count_q != `SWT_CNT_MAX) begin
        missed_sync_cycle_count_q <= missed_sync_cycle_count_q + 16'h0001;
      end else if (missed_sync_clr_wr && missed_sync_wdata == 16'h0000) begin
        missed_sync_cycle_count_q <= 16'h0000;
      end
    end
  end

  // status word and operating readouts
  // level inputs are mirrored one cycle late; bit 7 is reserved, zero
  always @(posedge clock) begin
    if (!rst_b) begin
      network_sleep_state_flags_q <= `SWT_STATUS_RST;
      operating_sleep_readout_q <= `SWT_SLEEP_RST;
      operating_wake_readout_q <= `SWT_WAKE_RST;
    end else begin
      network_sleep_state_flags_q <= {1'b0, deploy_mode, request_nominate,
                                      settings_nominate, cyc_sync_q, ever_sync_q,
                                      is_coordinator, state_q != ST_SLEEP};
      operating_sleep_readout_q <= eff_sleep;
      operating_wake_readout_q <= eff_wake;
    end
  end

endmodule // swt_sleep_wake_timing

//--- tb/swt_props.sv
/*
 checker for the sleep/wake timing block, watching its ports only.
 assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module swt_props (
  input wire clock, // clock
  input wire rst_b, // reset, active low
  input wire wake_time_wr, // wake write strobe
  input wire [23:0] wake_time_wdata, // wake write data
  input wire [23:0] wake_time_min, // wake floor
  input wire missed_sync_clr_wr, // count write strobe
  input wire [15:0] missed_sync_wdata, // count write data
  input wire host_char, // host character
  input wire is_coordinator, // coordinator level
  input wire deploy_mode, // deployment level
  input wire awake_q, // awake
  input wire host_out_ok_q, // output allowed
  input wire [23:0] wake_time_q, // stored wake time
  input wire [23:0] sleep_period_q, // stored sleep period
  input wire [7:0] network_sleep_state_flags_q, // status word
  input wire [23:0] operating_sleep_readout_q, // sleep readout
  input wire [15:0] cycles_since_sync_q, // cycles since sync
  input wire [15:0] missed_sync_cycle_count_q // missed count
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // stored wake time range, write path and floor
  wake_rng_a: assert property (wake_time_q >= 24'h000001 && wake_time_q <= 24'h36ee80)
    else $error("wake time out of range");
  wake_wr_a: assert property (wake_time_wr && wake_time_wdata >= wake_time_min
    && wake_time_wdata != 24'h0 && wake_time_wdata <= 24'h36ee80
    |=> wake_time_q == $past(wake_time_wdata)) else $error("wake write lost");
  wake_min_a: assert property (wake_time_q < wake_time_min && wake_time_min <= 24'h36ee80
    |-> ##[1:2] wake_time_q >= wake_time_min) else $error("wake not raised");
  // status word mirrors its levels and holds reset values
  flag_mir_a: assert property ($past(rst_b) |-> network_sleep_state_flags_q[1] ==
    $past(is_coordinator) && network_sleep_state_flags_q[6] == $past(deploy_mode)
    && !network_sleep_state_flags_q[7]) else $error("status bits wrong");
  rst_val_a: assert property (disable iff (1'b0) !rst_b |=>
    network_sleep_state_flags_q == 8'h40 && cycles_since_sync_q == 16'h0000
    && missed_sync_cycle_count_q == 16'h0000) else $error("reset value wrong");
  // missed count saturation and host writes
  miss_sat_a: assert property (missed_sync_cycle_count_q == 16'hffff && !missed_sync_clr_wr
    |=> missed_sync_cycle_count_q == 16'hffff) else $error("count wrapped");
  miss_clr_a: assert property (missed_sync_clr_wr && missed_sync_wdata == 16'h0000
    |=> missed_sync_cycle_count_q == 16'h0000 || $rose(awake_q))
    else $error("count not cleared");
  miss_keep_a: assert property (missed_sync_clr_wr && missed_sync_wdata != 16'h0000
    |=> missed_sync_cycle_count_q >= $past(missed_sync_cycle_count_q))
    else $error("count changed by write");
  // readout, sleep entry and host character
  os_cfg_a: assert property (!network_sleep_state_flags_q[2] && $stable(sleep_period_q)
    && $past(rst_b) |-> operating_sleep_readout_q == sleep_period_q) else $error("readout");
  sleep_cfg_a: assert property ($fell(awake_q) |-> sleep_period_q != 24'h000000)
    else $error("slept with zero period");
  char_ok_a: assert property (awake_q && host_char |-> ##[1:2] host_out_ok_q)
    else $error("host delay not stopped");
endmodule // swt_props

bind swt_sleep_wake_timing swt_props i_swt_props (.clock(clock), .rst_b(rst_b),
  .wake_time_wr(wake_time_wr), .wake_time_wdata(wake_time_wdata),
  .wake_time_min(wake_time_min), .missed_sync_clr_wr(missed_sync_clr_wr),
  .missed_sync_wdata(missed_sync_wdata), .host_char(host_char),
  .is_coordinator(is_coordinator), .deploy_mode(deploy_mode), .awake_q(awake_q),
  .host_out_ok_q(host_out_ok_q), .wake_time_q(wake_time_q), .sleep_period_q(sleep_period_q),
  .network_sleep_state_flags_q(network_sleep_state_flags_q),
  .operating_sleep_readout_q(operating_sleep_readout_q),
  .cycles_since_sync_q(cycles_since_sync_q),
  .missed_sync_cycle_count_q(missed_sync_cycle_count_q));

//--- tb/swt_peer.sv
/*
 far side model: radio peers and the host serial line.
 assumes requests from the bench; each becomes a one-cycle pulse.
*/
`timescale 1ns/1ps
module swt_peer (
  input wire clock, // clock
  input wire [2:0] go, // requests: sync, data, character
  output reg sync_rx, // sync pulse
  output reg rx_data, // data pulse
  output reg host_char, // host character pulse
  output wire [23:0] sync_sleep, // network sleep, 10 ms units
  output wire [23:0] sync_wake // network wake, ms
);
  // schedule carried by every sync
  assign sync_sleep = 24'h000001;
  assign sync_wake = 24'h000004;
  // quiet lines before the first edge
  initial {sync_rx, rx_data, host_char} = 3'h0;
  always @(posedge clock) begin
    {sync_rx, rx_data, host_char} <= go;
  end
endmodule // swt_peer

//--- tb/test_swt_sleep_wake_timing.sv
/*
 self-checking bench for the sleep/wake timing block.
 assumes the peer model for network and host pulses; ms shortened to 10 cycles.
*/
`timescale 1ns/1ps
`include "swt_defines.vh"
module test_swt_sleep_wake_timing;
  logic clock, rst_b, ww, sw, dw, cw;
  logic [3:0] mode, flg;
  logic [23:0] wd, wmin;
  logic [2:0] go;
  wire sync_rx, rx_data, host_char, awake_q, ok_q;
  wire [23:0] ss, swk, wt_q, sp_q, os_q, ow_q;
  wire [15:0] wh_q, css_q, msc_q;
  wire [7:0] fl_q;
  int err_total, compares, cyc, n;
  // wake write data beside the stored value it should give
  logic [47:0] rows [5] = '{{24'h000005, 24'h000005}, {24'h000000, 24'h000001},
    {24'h36ee80, 24'h36ee80}, {24'h36ee81, 24'h36ee80}, {24'hffffff, 24'h36ee80}};

  swt_sleep_wake_timing #(.MS_CYCLES(10), .UNICAST_MS(16'h0002)) i_swt_sleep_wake_timing (
    .clock(clock), .rst_b(rst_b), .sleep_mode_select(mode), .wake_time_wr(ww),
    .wake_time_wdata(wd), .wake_time_min(wmin), .sleep_period_wr(sw), .sleep_period_wdata(wd),
    .wake_host_delay_wr(dw), .wake_host_delay_wdata(wd[15:0]), .missed_sync_clr_wr(cw),
    .missed_sync_wdata(wd[15:0]), .rx_data(rx_data), .host_char(host_char),
    .sync_rx(sync_rx), .sync_sleep(ss), .sync_wake(swk), .is_coordinator(flg[0]),
    .settings_nominate(flg[1]), .request_nominate(flg[2]), .deploy_mode(flg[3]),
    .awake_q(awake_q), .host_out_ok_q(ok_q), .wake_time_q(wt_q), .sleep_period_q(sp_q),
    .wake_host_delay_q(wh_q), .network_sleep_state_flags_q(fl_q),
    .operating_sleep_readout_q(os_q), .operating_wake_readout_q(ow_q),
    .cycles_since_sync_q(css_q), .missed_sync_cycle_count_q(msc_q));
  swt_peer i_swt_peer (.clock(clock), .go(go), .sync_rx(sync_rx), .rx_data(rx_data),
    .host_char(host_char), .sync_sleep(ss), .sync_wake(swk));

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  // compare and count
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe: 0 wake, 1 sleep, 2 delay, 3 missed count
  task wr(input int s, input logic [23:0] d);
    @(posedge clock);
    {ww, sw, dw, cw} <= 4'h8 >> s;
    wd <= d;
    @(posedge clock);
    {ww, sw, dw, cw} <= 4'h0;
    repeat (2) @(posedge clock);
  endtask
  // length in cycles of the next run of awake at level v
  task meas(input logic v, output int k);
    k = 0;
    while (awake_q !== v) @(posedge clock);
    while (awake_q === v) begin
      @(posedge clock);
      k++;
    end
  endtask
  // one-cycle request to the peer
  task pulse(input logic [2:0] r);
    @(posedge clock);
    go <= r;
    @(posedge clock);
    go <= 3'h0;
  endtask
  task conclude;
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    {ww, sw, dw, cw, go, flg, mode} = '0;
    {wd, wmin, rst_b} = '0;
    {err_total, compares, cyc} = '0;
    repeat (10) @(posedge clock);
    chk({wt_q, sp_q, wh_q}, {`SWT_WAKE_RST, `SWT_SLEEP_RST, `SWT_WHD_RST});
    chk({os_q, ow_q, fl_q}, {24'h000190, 24'h001f40, 8'h40});
    chk({css_q, msc_q}, 32'h0);
    rst_b <= 1'b1;
    flg <= 4'hf;
    repeat (3) @(posedge clock);
    chk(fl_q & 8'hf2, 8'h72);
    flg <= 4'h0;
    foreach (rows[i]) begin
      wr(0, rows[i][47:24]);
      chk(wt_q, rows[i][23:0]);
    end
    chk(ow_q, 24'h36ee80);
    wr(0, 24'h000005);
    wmin <= 24'h000010;
    repeat (3) @(posedge clock);
    chk(wt_q, 24'h000010);
    wmin <= 24'h0;
    wr(0, 24'h000003);
    wr(1, 24'h000001);
    mode <= `SWT_MODE_ASYNC;
    meas(0, n);
    chk(n inside {[99:101]}, 1'b1);
    repeat (2) @(posedge clock);
    chk(msc_q, 16'h0001);
    chk(css_q !== 16'h0, 1'b1);
    repeat (8) @(posedge clock);
    pulse(3'b010);
    meas(1, n);
    chk(n inside {[30:34]}, 1'b1);
    wr(3, 24'h000005);
    chk(msc_q, 16'h0001);
    wr(3, 24'h000000);
    chk(msc_q, 16'h0000);
    pulse(3'b100);
    repeat (3) @(posedge clock);
    chk({fl_q[3:2], os_q, ow_q, css_q}, {2'b11, 24'h1, 24'h4, 16'h0});
    wr(2, 24'h000003);
    mode <= `SWT_MODE_SYNC;
    meas(0, n);
    meas(1, n);
    chk(n inside {[48:52]}, 1'b1);
    meas(0, n);
    chk(n inside {[68:72]}, 1'b1);
    repeat (2) @(posedge clock);
    chk(ok_q, 1'b0);
    pulse(3'b001);
    repeat (3) @(posedge clock);
    chk(ok_q, 1'b1);
    conclude();
  end
endmodule // test_swt_sleep_wake_timing
